// ### dram_bank_command_state.sv
// Per-bank and device-wide command state machine of a four-bank synchronous DRAM.
`timescale 1ns/1ns
module dram_bank_command_state
#(
	parameter int NUM_BANKS = dram_bank_pkg::NUM_BANKS,
	parameter int BANK_ADDR_WIDTH = dram_bank_pkg::BANK_ADDR_WIDTH,
	parameter int BURST_LEN = dram_bank_pkg::BURST_LEN,
	parameter int TIMER_WIDTH = dram_bank_pkg::TIMER_WIDTH,
	parameter int PRECHARGE_CYCLES = dram_bank_pkg::PRECHARGE_CYCLES,
	parameter int ACTIVATE_TO_ACCESS_CYCLES = dram_bank_pkg::ACTIVATE_TO_ACCESS_CYCLES,
	parameter int REFRESH_CYCLE_CYCLES = dram_bank_pkg::REFRESH_CYCLE_CYCLES,
	parameter int MODE_LOAD_CYCLES = dram_bank_pkg::MODE_LOAD_CYCLES,
	parameter int SELF_REFRESH_EXIT_CYCLES = dram_bank_pkg::SELF_REFRESH_EXIT_CYCLES
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Command pins from the controller
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_ADDR_WIDTH-1:0] bank_addr,
	input wire logic auto_precharge,
	// Power logic
	input wire logic self_refresh_exit,
	// Bank status
	output logic [NUM_BANKS-1:0] bank_idle,
	output logic [NUM_BANKS-1:0] bank_row_open,
	output logic [NUM_BANKS-1:0] bank_timed,
	output logic all_banks_idle,
	output logic device_busy,
	output logic command_refused,
	// Burst beats
	output logic burst_beat,
	output logic burst_beat_write,
	output logic [BANK_ADDR_WIDTH-1:0] burst_beat_bank
);

	localparam int BURST_WIDTH = $clog2(BURST_LEN + 1);
	localparam logic SINGLE_BEAT = (BURST_LEN == 1);

	function automatic logic bank_allows(input dram_bank_pkg::bank_state_t s, input dram_bank_pkg::cmd_t c);
		case (s)
			dram_bank_pkg::BANK_IDLE:
				bank_allows = (c == dram_bank_pkg::CMD_ACTIVE) || (c == dram_bank_pkg::CMD_PRECHARGE);
			dram_bank_pkg::BANK_ACTIVE, dram_bank_pkg::BANK_READ, dram_bank_pkg::BANK_WRITE:
				bank_allows = (c == dram_bank_pkg::CMD_READ) || (c == dram_bank_pkg::CMD_WRITE)
					|| (c == dram_bank_pkg::CMD_PRECHARGE);
			default:
				bank_allows = 1'b0;
		endcase
	endfunction

	function automatic logic precharge_ok(input dram_bank_pkg::bank_state_t s);
		precharge_ok = bank_allows(s, dram_bank_pkg::CMD_PRECHARGE);
	endfunction

	dram_bank_pkg::cmd_t cmd;
	dram_bank_pkg::bank_state_t bank_state [NUM_BANKS];
	dram_bank_pkg::dev_state_t dev_state_reg;
	dram_bank_pkg::dev_state_t dev_state_next;
	dram_bank_pkg::bank_state_t target_state;
	logic cke_prev_reg;
	logic cmd_enable;
	logic executable;
	logic accept;
	logic every_idle;
	logic every_precharge_ok;
	logic do_act;
	logic do_rd;
	logic do_wr;
	logic do_pre;
	logic do_pre_all;
	logic do_ref;
	logic do_lmr;
	logic do_bst;
	logic new_burst;
	logic kill;
	logic natural_end;
	logic dev_load;
	logic [TIMER_WIDTH-1:0] dev_load_value;
	logic dev_expire;
	logic burst_active_reg;
	logic burst_write_reg;
	logic burst_ap_reg;
	logic [BANK_ADDR_WIDTH-1:0] burst_bank_reg;
	logic [BURST_WIDTH-1:0] burst_left_reg;

	dram_cmd_decode u_decode
	(
		.cs_n(cs_n),
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.cmd(cmd)
	);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			cke_prev_reg <= 1'b0;
		else
			cke_prev_reg <= cke;
	end

	// Device-wide timed states and the exit time swallow every command.
	assign cmd_enable = cke_prev_reg && cke && (dev_state_reg == dram_bank_pkg::DEV_NORMAL);
	assign executable = (cmd != dram_bank_pkg::CMD_INHIBIT) && (cmd != dram_bank_pkg::CMD_NOP);
	assign target_state = bank_state[bank_addr];

	always_comb
	begin
		every_idle = 1'b1;
		every_precharge_ok = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++)
		begin
			if (bank_state[i] != dram_bank_pkg::BANK_IDLE)
				every_idle = 1'b0;
			if (!precharge_ok(bank_state[i]))
				every_precharge_ok = 1'b0;
		end
	end

	// Legality: access and single precharge check the target bank, precharge all, refresh and mode load every bank, burst stop the burst.
	always_comb
	begin
		accept = 1'b0;
		if (cmd_enable)
		begin
			case (cmd)
				dram_bank_pkg::CMD_ACTIVE, dram_bank_pkg::CMD_READ, dram_bank_pkg::CMD_WRITE:
					accept = bank_allows(target_state, cmd);
				dram_bank_pkg::CMD_PRECHARGE:
					accept = auto_precharge ? every_precharge_ok : bank_allows(target_state, cmd);
				dram_bank_pkg::CMD_REFRESH, dram_bank_pkg::CMD_LOAD_MODE:
					accept = every_idle;
				dram_bank_pkg::CMD_BURST_STOP:
					accept = burst_active_reg && !burst_ap_reg;
				default:
					accept = 1'b0;
			endcase
		end
	end

	assign do_act = accept && (cmd == dram_bank_pkg::CMD_ACTIVE);
	assign do_rd = accept && (cmd == dram_bank_pkg::CMD_READ);
	assign do_wr = accept && (cmd == dram_bank_pkg::CMD_WRITE);
	assign do_pre = accept && (cmd == dram_bank_pkg::CMD_PRECHARGE) && !auto_precharge;
	assign do_pre_all = accept && (cmd == dram_bank_pkg::CMD_PRECHARGE) && auto_precharge;
	assign do_ref = accept && (cmd == dram_bank_pkg::CMD_REFRESH);
	assign do_lmr = accept && (cmd == dram_bank_pkg::CMD_LOAD_MODE);
	assign do_bst = accept && (cmd == dram_bank_pkg::CMD_BURST_STOP);
	assign new_burst = do_rd || do_wr;

	// A refused command is ignored; the flag is only a diagnostic for the controller side.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			command_refused <= 1'b0;
		else
			command_refused <= cke_prev_reg && cke && executable && !accept;
	end

	// Burst tracking: one burst runs at a time, and a newer one replaces it.
	assign kill = do_bst || do_pre_all || (do_pre && (bank_addr == burst_bank_reg));
	assign natural_end = burst_active_reg && (burst_left_reg == BURST_WIDTH'(1)) && !kill && !new_burst;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			burst_active_reg <= 1'b0;
			burst_write_reg <= 1'b0;
			burst_ap_reg <= 1'b0;
			burst_bank_reg <= '0;
			burst_left_reg <= '0;
		end
		else if (new_burst)
		begin
			burst_active_reg <= !SINGLE_BEAT;
			burst_write_reg <= do_wr;
			burst_ap_reg <= auto_precharge;
			burst_bank_reg <= bank_addr;
			burst_left_reg <= BURST_WIDTH'(BURST_LEN - 1);
		end
		else if (kill || natural_end)
			burst_active_reg <= 1'b0;
		else if (burst_active_reg)
			burst_left_reg <= burst_left_reg - BURST_WIDTH'(1);
	end

	// The beat on an interrupting command's edge belongs to the new burst, so the old
	// write's last beat is the one before it.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			burst_beat <= 1'b0;
			burst_beat_write <= 1'b0;
			burst_beat_bank <= '0;
		end
		else
		begin
			burst_beat <= new_burst || (burst_active_reg && !kill);
			burst_beat_write <= new_burst ? do_wr : burst_write_reg;
			burst_beat_bank <= new_burst ? bank_addr : burst_bank_reg;
		end
	end

	// Per-bank state machines, each with its own timer.
	for (genvar b = 0; b < NUM_BANKS; b++)
	begin : g_bank
		dram_bank_pkg::bank_state_t state_reg;
		dram_bank_pkg::bank_state_t state_next;
		logic sel;
		logic finish_here;
		logic load;
		logic [TIMER_WIDTH-1:0] load_value;
		logic expire;

		assign sel = (bank_addr == BANK_ADDR_WIDTH'(b));
		assign finish_here = burst_active_reg && (burst_bank_reg == BANK_ADDR_WIDTH'(b))
			&& (kill || new_burst || natural_end);

		always_comb
		begin
			state_next = state_reg;
			load = 1'b0;
			load_value = TIMER_WIDTH'(PRECHARGE_CYCLES);
			if (do_pre_all && (state_reg != dram_bank_pkg::BANK_IDLE))
			begin
				state_next = dram_bank_pkg::BANK_PRECHARGING;
				load = 1'b1;
			end
			else if (sel && do_act)
			begin
				state_next = dram_bank_pkg::BANK_ACTIVATING;
				load = 1'b1;
				load_value = TIMER_WIDTH'(ACTIVATE_TO_ACCESS_CYCLES);
			end
			else if (sel && new_burst)
			begin
				if (SINGLE_BEAT)
				begin
					state_next = auto_precharge ? dram_bank_pkg::BANK_PRECHARGING : dram_bank_pkg::BANK_ACTIVE;
					load = auto_precharge;
				end
				else if (auto_precharge)
					state_next = do_wr ? dram_bank_pkg::BANK_WRITE_AP : dram_bank_pkg::BANK_READ_AP;
				else
					state_next = do_wr ? dram_bank_pkg::BANK_WRITE : dram_bank_pkg::BANK_READ;
			end
			else if (sel && do_pre && (state_reg != dram_bank_pkg::BANK_IDLE))
			begin
				state_next = dram_bank_pkg::BANK_PRECHARGING;
				load = 1'b1;
			end
			else
			begin
				case (state_reg)
					dram_bank_pkg::BANK_ACTIVATING:
						if (expire)
							state_next = dram_bank_pkg::BANK_ACTIVE;
					dram_bank_pkg::BANK_PRECHARGING:
						if (expire)
							state_next = dram_bank_pkg::BANK_IDLE;
					dram_bank_pkg::BANK_READ, dram_bank_pkg::BANK_WRITE:
						if (finish_here)
							state_next = dram_bank_pkg::BANK_ACTIVE;
					dram_bank_pkg::BANK_READ_AP, dram_bank_pkg::BANK_WRITE_AP:
						if (finish_here)
						begin
							state_next = dram_bank_pkg::BANK_PRECHARGING;
							load = 1'b1;
						end
					default:
						state_next = state_reg;
				endcase
			end
		end

		always_ff @(posedge clk_sys)
		begin
			if (reset)
				state_reg <= dram_bank_pkg::BANK_IDLE;
			else
				state_reg <= state_next;
		end

		dram_state_timer #(.WIDTH(TIMER_WIDTH)) u_timer
		(
			.clk_sys(clk_sys),
			.reset(reset),
			.load(load),
			.load_value(load_value),
			.expire(expire),
			.running()
		);

		assign bank_state[b] = state_reg;
		assign bank_idle[b] = (state_reg == dram_bank_pkg::BANK_IDLE);
		assign bank_row_open[b] = (state_reg == dram_bank_pkg::BANK_ACTIVE) || (state_reg == dram_bank_pkg::BANK_READ)
			|| (state_reg == dram_bank_pkg::BANK_WRITE);
		assign bank_timed[b] = (state_reg == dram_bank_pkg::BANK_ACTIVATING)
			|| (state_reg == dram_bank_pkg::BANK_PRECHARGING) || (state_reg == dram_bank_pkg::BANK_READ_AP)
			|| (state_reg == dram_bank_pkg::BANK_WRITE_AP);
	end

	// Device-wide state. Precharge all runs here and in every bank not idle for the same time.
	always_comb
	begin
		dev_state_next = dev_state_reg;
		dev_load = 1'b0;
		dev_load_value = TIMER_WIDTH'(PRECHARGE_CYCLES);
		case (dev_state_reg)
			dram_bank_pkg::DEV_NORMAL:
				if (self_refresh_exit)
				begin
					dev_state_next = dram_bank_pkg::DEV_SR_EXIT;
					dev_load = 1'b1;
					dev_load_value = TIMER_WIDTH'(SELF_REFRESH_EXIT_CYCLES);
				end
				else if (do_ref)
				begin
					dev_state_next = dram_bank_pkg::DEV_REFRESH;
					dev_load = 1'b1;
					dev_load_value = TIMER_WIDTH'(REFRESH_CYCLE_CYCLES);
				end
				else if (do_lmr)
				begin
					dev_state_next = dram_bank_pkg::DEV_MODE_LOAD;
					dev_load = 1'b1;
					dev_load_value = TIMER_WIDTH'(MODE_LOAD_CYCLES);
				end
				else if (do_pre_all)
				begin
					dev_state_next = dram_bank_pkg::DEV_PRECHARGE_ALL;
					dev_load = 1'b1;
				end
			default:
				if (dev_expire)
					dev_state_next = dram_bank_pkg::DEV_NORMAL;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			dev_state_reg <= dram_bank_pkg::DEV_NORMAL;
		else
			dev_state_reg <= dev_state_next;
	end

	dram_state_timer #(.WIDTH(TIMER_WIDTH)) u_dev_timer
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.load(dev_load),
		.load_value(dev_load_value),
		.expire(dev_expire),
		.running()
	);

	assign device_busy = (dev_state_reg != dram_bank_pkg::DEV_NORMAL);
	assign all_banks_idle = every_idle && !device_busy;

endmodule

// ### dram_bank_command_state_properties.sv
// Concurrent checks of the bank command state block, bound to its top module.
`timescale 1ns/1ns
module dram_bank_command_state_properties
#(
	parameter int NUM_BANKS = 4,
	parameter int BANK_ADDR_WIDTH = 2,
	parameter int PRECHARGE_CYCLES = 1,
	parameter int ACTIVATE_TO_ACCESS_CYCLES = 1,
	parameter int REFRESH_CYCLE_CYCLES = 2,
	parameter int MODE_LOAD_CYCLES = 2,
	parameter int SELF_REFRESH_EXIT_CYCLES = 3
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_ADDR_WIDTH-1:0] bank_addr,
	input wire logic auto_precharge,
	input wire logic self_refresh_exit,
	// Status
	input wire logic [NUM_BANKS-1:0] bank_idle,
	input wire logic [NUM_BANKS-1:0] bank_row_open,
	input wire logic [NUM_BANKS-1:0] bank_timed,
	input wire logic all_banks_idle,
	input wire logic device_busy,
	input wire logic command_refused,
	input wire logic burst_beat,
	input wire logic burst_beat_write,
	input wire logic [BANK_ADDR_WIDTH-1:0] burst_beat_bank
);
	localparam int PRE_D = PRECHARGE_CYCLES + 1;
	localparam int ACT_D = ACTIVATE_TO_ACCESS_CYCLES + 1;
	localparam int REF_M1 = REFRESH_CYCLE_CYCLES - 1;
	localparam int MLD_M1 = MODE_LOAD_CYCLES - 1;
	localparam int SRX_M1 = SELF_REFRESH_EXIT_CYCLES - 1;
	logic cke_reg;
	logic [2:0] pat;
	logic live;
	always_ff @(posedge clk_sys)
	begin
		cke_reg <= reset ? 1'b0 : cke;
	end
	assign pat = {ras_n, cas_n, we_n};
	// Busy edges are left out so that each check built on live only sees commands the bank state decides.
	assign live = cke && cke_reg && !cs_n && !device_busy;
	default clocking def_clk @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	chk_reset_all_idle:
		assert property ($fell(reset) |-> bank_idle == '1 && all_banks_idle && !device_busy && !burst_beat)
			else $error("Banks not idle after reset");
	chk_cke_ignored:
		assert property ((!cke || !cke_reg) && all_banks_idle |=> bank_idle == '1 && !command_refused)
			else $error("Command taken without clock enable on both edges");
	chk_exit_time:
		assert property (self_refresh_exit && all_banks_idle |=> device_busy ##SRX_M1 device_busy ##1 !device_busy)
			else $error("Self refresh exit time wrong");
	chk_activate_time:
		assert property (live && pat == dram_bank_pkg::PAT_ACTIVE && bank_idle[bank_addr]
			|=> bank_timed[$past(bank_addr)] ##ACTIVATE_TO_ACCESS_CYCLES bank_row_open[$past(bank_addr, ACT_D)])
			else $error("Activation did not end in row active on time");
	chk_precharge_time:
		assert property (live && pat == dram_bank_pkg::PAT_PRECHARGE && !auto_precharge && bank_row_open[bank_addr]
			|=> bank_timed[$past(bank_addr)] ##PRECHARGE_CYCLES bank_idle[$past(bank_addr, PRE_D)])
			else $error("Precharge did not end in idle on time");
	chk_burst_start:
		assert property (live && pat[2:1] == 2'h2 && bank_row_open[bank_addr] |=> burst_beat
			&& burst_beat_write == !$past(we_n) && burst_beat_bank == $past(bank_addr)
			&& bank_timed[$past(bank_addr)] == $past(auto_precharge))
			else $error("Burst start wrong");
	chk_refresh_time:
		assert property (live && pat == dram_bank_pkg::PAT_REFRESH && all_banks_idle
			|=> device_busy ##REF_M1 device_busy ##1 all_banks_idle)
			else $error("Refresh time wrong");
	chk_mode_load_time:
		assert property (live && pat == dram_bank_pkg::PAT_LOAD_MODE && all_banks_idle
			|=> device_busy ##MLD_M1 device_busy ##1 all_banks_idle)
			else $error("Mode load time wrong");
	chk_precharge_all:
		assert property (live && pat == dram_bank_pkg::PAT_PRECHARGE && auto_precharge && bank_timed == '0
			|=> device_busy ##PRECHARGE_CYCLES bank_idle == '1 && !device_busy)
			else $error("Precharge all wrong");
	chk_busy_refusal:
		assert property (cke && cke_reg && !cs_n && device_busy && pat != dram_bank_pkg::PAT_NOP |=> command_refused)
			else $error("Command during device busy not refused");
	chk_idle_access_refusal:
		assert property (live && pat[2:1] == 2'h2 && bank_idle[bank_addr]
			|=> command_refused && !(burst_beat && burst_beat_bank == $past(bank_addr)))
			else $error("Access to idle bank not refused");
endmodule
bind dram_bank_command_state dram_bank_command_state_properties #(
	.NUM_BANKS(NUM_BANKS), .BANK_ADDR_WIDTH(BANK_ADDR_WIDTH), .PRECHARGE_CYCLES(PRECHARGE_CYCLES),
	.ACTIVATE_TO_ACCESS_CYCLES(ACTIVATE_TO_ACCESS_CYCLES), .REFRESH_CYCLE_CYCLES(REFRESH_CYCLE_CYCLES),
	.MODE_LOAD_CYCLES(MODE_LOAD_CYCLES), .SELF_REFRESH_EXIT_CYCLES(SELF_REFRESH_EXIT_CYCLES)
) props (
	.clk_sys(clk_sys), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.bank_addr(bank_addr), .auto_precharge(auto_precharge), .self_refresh_exit(self_refresh_exit),
	.bank_idle(bank_idle), .bank_row_open(bank_row_open), .bank_timed(bank_timed),
	.all_banks_idle(all_banks_idle), .device_busy(device_busy), .command_refused(command_refused),
	.burst_beat(burst_beat), .burst_beat_write(burst_beat_write), .burst_beat_bank(burst_beat_bank)
);

// ### dram_bank_command_state_test.sv
// Self-checking testbench of the bank command state block.
`timescale 1ns/1ns
module dram_bank_command_state_test;
	logic clk_sys;
	logic reset;
	logic self_refresh_exit;
	logic cke, cs_n, ras_n, cas_n, we_n, auto_precharge;
	logic [1:0] bank_addr;
	logic [1:0] burst_beat_bank;
	logic [3:0] bank_idle, bank_row_open, bank_timed;
	logic all_banks_idle, device_busy, command_refused, burst_beat, burst_beat_write;
	int failures;
	int tests_run;
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	dram_ctrl_model ctl (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_addr(bank_addr), .auto_precharge(auto_precharge));
	dram_bank_command_state dut (.clk_sys(clk_sys), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .auto_precharge(auto_precharge),
		.self_refresh_exit(self_refresh_exit), .bank_idle(bank_idle), .bank_row_open(bank_row_open),
		.bank_timed(bank_timed), .all_banks_idle(all_banks_idle), .device_busy(device_busy),
		.command_refused(command_refused), .burst_beat(burst_beat), .burst_beat_write(burst_beat_write),
		.burst_beat_bank(burst_beat_bank));
	task automatic check_vec(input logic [3:0] got, input logic [3:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input string what);
		check_vec({3'h0, got}, {3'h0, exp}, what);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Returns just after the edge that takes the command, with the pins already back to deselect.
	task automatic issue(input logic [2:0] pat, input logic [1:0] b, input logic ap);
		ctl.drive(pat, b, ap);
		ctl.drive(dram_bank_pkg::PAT_NOP, b, 1'b0);
		#1;
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic test_activate_read();
		logic [3:0] n;
		n = 4'h0;
		issue(dram_bank_pkg::PAT_ACTIVE, 2'h0, 1'b0);
		check_vec(bank_timed, 4'h1, "activating bank");
		cycles(dram_bank_pkg::ACTIVATE_TO_ACCESS_CYCLES);
		check_vec(bank_row_open, 4'h1, "row active bank");
		issue(dram_bank_pkg::PAT_READ, 2'h0, 1'b0);
		repeat (dram_bank_pkg::BURST_LEN + 2)
		begin
			n = n + {3'h0, burst_beat};
			cycles(1);
		end
		check_vec(n, 4'(dram_bank_pkg::BURST_LEN), "read beat count");
		check_vec(bank_row_open, 4'h1, "row open after read");
		$display("Test activate_read done");
	endtask
	task automatic test_interleave();
		issue(dram_bank_pkg::PAT_ACTIVE, 2'h1, 1'b0);
		cycles(dram_bank_pkg::ACTIVATE_TO_ACCESS_CYCLES);
		check_vec(bank_row_open, 4'h3, "second bank active");
		ctl.drive(dram_bank_pkg::PAT_WRITE, 2'h0, 1'b1);
		ctl.drive(dram_bank_pkg::PAT_READ, 2'h1, 1'b0);
		ctl.drive(dram_bank_pkg::PAT_NOP, 2'h1, 1'b0);
		#1;
		check_bit(burst_beat_write, 1'b0, "interrupting beat kind");
		check_vec({2'h0, burst_beat_bank}, 4'h1, "interrupting beat bank");
		check_bit(bank_timed[0], 1'b1, "interrupted bank precharging");
		cycles(dram_bank_pkg::PRECHARGE_CYCLES);
		check_bit(bank_idle[0], 1'b1, "auto precharged bank idle");
		$display("Test interleave done");
	endtask
	task automatic test_stop_precharge();
		issue(dram_bank_pkg::PAT_BURST_STOP, 2'h0, 1'b0);
		check_bit(burst_beat, 1'b0, "beat after stop");
		check_bit(command_refused, 1'b0, "stop refused");
		issue(dram_bank_pkg::PAT_PRECHARGE, 2'h1, 1'b0);
		check_bit(bank_timed[1], 1'b1, "bank precharging");
		cycles(dram_bank_pkg::PRECHARGE_CYCLES);
		check_vec(bank_idle, 4'hF, "precharged bank idle");
		issue(dram_bank_pkg::PAT_PRECHARGE, 2'h2, 1'b0);
		check_vec(bank_timed, 4'h0, "idle bank precharge");
		check_bit(command_refused, 1'b0, "idle bank precharge refused");
		$display("Test stop_precharge done");
	endtask
	task automatic test_refresh_mode();
		ctl.drive(dram_bank_pkg::PAT_REFRESH, 2'h0, 1'b0);
		ctl.drive(dram_bank_pkg::PAT_ACTIVE, 2'h3, 1'b0);
		ctl.drive(dram_bank_pkg::PAT_NOP, 2'h3, 1'b0);
		#1;
		check_bit(device_busy, 1'b1, "refreshing");
		check_bit(command_refused, 1'b1, "command in refresh");
		check_vec(bank_idle, 4'hF, "banks in refresh");
		cycles(dram_bank_pkg::REFRESH_CYCLE_CYCLES - 1);
		check_bit(all_banks_idle, 1'b1, "after refresh");
		issue(dram_bank_pkg::PAT_LOAD_MODE, 2'h0, 1'b0);
		check_bit(device_busy, 1'b1, "mode loading");
		cycles(dram_bank_pkg::MODE_LOAD_CYCLES);
		check_bit(all_banks_idle, 1'b1, "after mode load");
		issue(dram_bank_pkg::PAT_ACTIVE, 2'h0, 1'b0);
		cycles(dram_bank_pkg::ACTIVATE_TO_ACCESS_CYCLES);
		issue(dram_bank_pkg::PAT_REFRESH, 2'h0, 1'b0);
		check_bit(command_refused, 1'b1, "refresh with open row");
		check_bit(device_busy, 1'b0, "refresh with open row busy");
		$display("Test refresh_mode done");
	endtask
	task automatic test_precharge_all();
		issue(dram_bank_pkg::PAT_ACTIVE, 2'h3, 1'b0);
		cycles(dram_bank_pkg::ACTIVATE_TO_ACCESS_CYCLES);
		issue(dram_bank_pkg::PAT_PRECHARGE, 2'h0, 1'b1);
		check_bit(device_busy, 1'b1, "precharging all");
		cycles(dram_bank_pkg::PRECHARGE_CYCLES);
		check_vec(bank_idle, 4'hF, "all precharged");
		check_bit(device_busy, 1'b0, "precharge all over");
		$display("Test precharge_all done");
	endtask
	task automatic test_clock_enable();
		ctl.drive(dram_bank_pkg::PAT_ACTIVE, 2'h2, 1'b0);
		ctl.set_cke(1'b0);
		ctl.drive(dram_bank_pkg::PAT_ACTIVE, 2'h2, 1'b0);
		ctl.set_cke(1'b1);
		ctl.drive(dram_bank_pkg::PAT_NOP, 2'h2, 1'b0);
		#1;
		check_vec(bank_idle, 4'hF, "command without clock enable");
		check_bit(command_refused, 1'b0, "flag without clock enable");
		@(posedge clk_sys);
		self_refresh_exit <= 1'b1;
		@(posedge clk_sys);
		self_refresh_exit <= 1'b0;
		cycles(dram_bank_pkg::SELF_REFRESH_EXIT_CYCLES - 1);
		check_bit(device_busy, 1'b1, "exit time last cycle");
		cycles(1);
		check_bit(device_busy, 1'b0, "exit time over");
		$display("Test clock_enable done");
	endtask
	task automatic test_illegal();
		issue(dram_bank_pkg::PAT_READ, 2'h2, 1'b0);
		check_bit(command_refused, 1'b1, "read to idle bank");
		check_bit(burst_beat, 1'b0, "beat from idle bank");
		issue(dram_bank_pkg::PAT_BURST_STOP, 2'h0, 1'b0);
		check_bit(command_refused, 1'b1, "stop with no burst");
		$display("Test illegal done");
	endtask
	initial
	begin
		reset = 1'b1;
		self_refresh_exit = 1'b0;
		failures = 0;
		tests_run = 0;
		repeat (10) @(posedge clk_sys);
		ctl.set_cke(1'b1);
		reset <= 1'b0;
		cycles(2);
		check_vec(bank_idle, 4'hF, "banks after reset");
		check_bit(device_busy, 1'b0, "busy after reset");
		test_activate_read();
		test_interleave();
		test_stop_precharge();
		test_refresh_mode();
		test_precharge_all();
		test_clock_enable();
		test_illegal();
		wrap_up();
	end
endmodule

// ### dram_bank_pkg.sv
// Shared constants, timing figures and enumerations for the bank command state logic.
package dram_bank_pkg;

	localparam int CLK_PERIOD_NS = 50;

	// Timing figures in nanoseconds. These are plain defaults; set them to the part in use.
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int ACTIVATE_TO_ACCESS_TIME_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 80;
	localparam int MODE_LOAD_TIME_NS = 100;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 120;

	// Least times round up to whole cycles, and never below one cycle.
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int PRECHARGE_CYCLES = ns_to_cycles(PRECHARGE_TIME_NS);
	localparam int ACTIVATE_TO_ACCESS_CYCLES = ns_to_cycles(ACTIVATE_TO_ACCESS_TIME_NS);
	localparam int REFRESH_CYCLE_CYCLES = ns_to_cycles(REFRESH_CYCLE_TIME_NS);
	localparam int MODE_LOAD_CYCLES = ns_to_cycles(MODE_LOAD_TIME_NS);
	localparam int SELF_REFRESH_EXIT_CYCLES = ns_to_cycles(SELF_REFRESH_EXIT_TIME_NS);

	localparam int TIMER_WIDTH = 8;
	localparam int NUM_BANKS = 4;
	localparam int BANK_ADDR_WIDTH = 2;
	localparam int BURST_LEN = 4;

	// Strobe patterns as {row strobe, column strobe, write enable}, all active low.
	localparam logic [2:0] PAT_NOP = 3'h7;
	localparam logic [2:0] PAT_ACTIVE = 3'h3;
	localparam logic [2:0] PAT_READ = 3'h5;
	localparam logic [2:0] PAT_WRITE = 3'h4;
	localparam logic [2:0] PAT_PRECHARGE = 3'h2;
	localparam logic [2:0] PAT_REFRESH = 3'h1;
	localparam logic [2:0] PAT_LOAD_MODE = 3'h0;
	localparam logic [2:0] PAT_BURST_STOP = 3'h6;

	typedef enum logic [3:0] {
		CMD_INHIBIT,
		CMD_NOP,
		CMD_ACTIVE,
		CMD_READ,
		CMD_WRITE,
		CMD_PRECHARGE,
		CMD_REFRESH,
		CMD_LOAD_MODE,
		CMD_BURST_STOP
	} cmd_t;

	typedef enum logic [2:0] {
		BANK_IDLE,
		BANK_ACTIVATING,
		BANK_ACTIVE,
		BANK_READ,
		BANK_WRITE,
		BANK_READ_AP,
		BANK_WRITE_AP,
		BANK_PRECHARGING
	} bank_state_t;

	typedef enum logic [2:0] {
		DEV_NORMAL,
		DEV_REFRESH,
		DEV_MODE_LOAD,
		DEV_PRECHARGE_ALL,
		DEV_SR_EXIT
	} dev_state_t;

endpackage

// ### dram_cmd_decode.sv
// Decoder from the chip select and strobe pins to a command code.
`timescale 1ns/1ns
module dram_cmd_decode
(
	// Command pins, active low
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	// Decoded command
	output dram_bank_pkg::cmd_t cmd
);

	always_comb
	begin
		cmd = dram_bank_pkg::CMD_INHIBIT;
		if (!cs_n)
		begin
			case ({ras_n, cas_n, we_n})
				dram_bank_pkg::PAT_NOP: cmd = dram_bank_pkg::CMD_NOP;
				dram_bank_pkg::PAT_ACTIVE: cmd = dram_bank_pkg::CMD_ACTIVE;
				dram_bank_pkg::PAT_READ: cmd = dram_bank_pkg::CMD_READ;
				dram_bank_pkg::PAT_WRITE: cmd = dram_bank_pkg::CMD_WRITE;
				dram_bank_pkg::PAT_PRECHARGE: cmd = dram_bank_pkg::CMD_PRECHARGE;
				dram_bank_pkg::PAT_REFRESH: cmd = dram_bank_pkg::CMD_REFRESH;
				dram_bank_pkg::PAT_LOAD_MODE: cmd = dram_bank_pkg::CMD_LOAD_MODE;
				dram_bank_pkg::PAT_BURST_STOP: cmd = dram_bank_pkg::CMD_BURST_STOP;
				default: cmd = dram_bank_pkg::CMD_NOP;
			endcase
		end
	end

endmodule

// ### dram_ctrl_model.sv
// Behavioural memory controller that drives the command pins of the bank state block.
`timescale 1ns/1ns
module dram_ctrl_model
(
	// Clock
	input wire logic clk_sys,
	// Command pins
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [dram_bank_pkg::BANK_ADDR_WIDTH-1:0] bank_addr,
	output logic auto_precharge
);
	logic data_mask;
	initial
	begin
		cke = 1'b0;
		data_mask = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = dram_bank_pkg::PAT_NOP;
		bank_addr = 2'h0;
		auto_precharge = 1'b0;
	end
	// One command per edge; callers chain calls for back-to-back traffic and send idle cycles between.
	task automatic drive(input logic [2:0] pat, input logic [1:0] bank, input logic ap);
		@(posedge clk_sys);
		// A write first gets one deselected edge with the mask up, so read data clears the bus.
		data_mask <= (pat == dram_bank_pkg::PAT_WRITE);
		if (pat == dram_bank_pkg::PAT_WRITE)
		begin
			cs_n <= 1'b1;
			@(posedge clk_sys);
			data_mask <= 1'b0;
		end
		cs_n <= (pat == dram_bank_pkg::PAT_NOP);
		{ras_n, cas_n, we_n} <= pat;
		// A NOP's bank address is inverted, not held, so a stale value cannot pass for a real one.
		bank_addr <= (pat == dram_bank_pkg::PAT_NOP) ? ~bank : bank;
		auto_precharge <= ap;
	endtask
	task automatic set_cke(input logic v);
		cke <= v;
	endtask
endmodule

// ### dram_state_timer.sv
// Down counter that times one timed state and flags its last cycle.
`timescale 1ns/1ns
module dram_state_timer
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	// Status
	output logic expire,
	output logic running
);

	logic [WIDTH-1:0] count_reg;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			count_reg <= '0;
		else if (load)
			count_reg <= load_value;
		else if (count_reg != '0)
			count_reg <= count_reg - WIDTH'(1);
	end

	// The owner leaves its timed state on the edge that sees the last count.
	assign expire = (count_reg == WIDTH'(1));
	assign running = (count_reg != '0);

endmodule
